// ---- pkg/shm_pkg.sv ----
// shm_pkg: constants shared by the sha-1 mac coprocessor files
package shm_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam int unsigned ADDR_W    = 5;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned BUF_WORDS = 16;
  localparam logic [4:0]  BUF_LAST  = 5'h0F;
  localparam logic [4:0]  RES_A     = 5'h10;
  localparam logic [4:0]  RES_B     = 5'h11;
  localparam logic [4:0]  RES_C     = 5'h12;
  localparam logic [4:0]  RES_D     = 5'h13;
  localparam logic [4:0]  RES_E     = 5'h14;

  // ****************************************
  // round schedule
  // ****************************************
  localparam logic [6:0] ROUND_LAST = 7'h4F;  // 80 rounds, 0..79
  localparam logic [6:0] PHASE_1    = 7'h14;  // round 20
  localparam logic [6:0] PHASE_2    = 7'h28;  // round 40
  localparam logic [6:0] PHASE_3    = 7'h3C;  // round 60
  localparam logic [6:0] SCHED_FROM = 7'h10;  // round 16

  // ****************************************
  // initial chaining value and round constants
  // ****************************************
  localparam logic [31:0] IV_A = 32'h6745_2301;
  localparam logic [31:0] IV_B = 32'hEFCD_AB89;
  localparam logic [31:0] IV_C = 32'h98BA_DCFE;
  localparam logic [31:0] IV_D = 32'h1032_5476;
  localparam logic [31:0] IV_E = 32'hC3D2_E1F0;
  localparam logic [31:0] K_0  = 32'h5A82_7999;
  localparam logic [31:0] K_1  = 32'h6ED9_EBA1;
  localparam logic [31:0] K_2  = 32'h8F1B_BCDC;
  localparam logic [31:0] K_3  = 32'hCA62_C1D6;

  // ****************************************
  // control states
  // ****************************************
  typedef enum logic [0:0] {
    SHM_IDLE,
    SHM_RUN
  } shm_state_e;

endpackage

// ---- pkg/shm_round_if.sv ----
// shm_round_if: working state and word between core and round logic
`timescale 1ns/1ps
interface shm_round_if;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] c;
  logic [31:0] d;
  logic [31:0] e;
  logic [31:0] w;
  logic [6:0]  idx;
  logic [31:0] a_n;
  logic [31:0] c_n;

  modport core (output a, b, c, d, e, w, idx, input a_n, c_n);
  modport rnd  (input a, b, c, d, e, w, idx, output a_n, c_n);
endinterface

// ---- rtl/shm_round.sv ----
// shm_round: combinational sha-1 compression round
`timescale 1ns/1ps
module shm_round (
  shm_round_if.rnd rif  // state in, next state out
);

  // ****************************************
  // round functions
  // ****************************************
  function automatic logic [31:0] rotl(input logic [31:0] x,
                                       input int unsigned n);
    rotl = (x << n) | (x >> (32 - n));
  endfunction

  function automatic logic [31:0] mix_fn(input logic [6:0]  i,
                                         input logic [31:0] b,
                                         input logic [31:0] c,
                                         input logic [31:0] d);
    if (i < shm_pkg::PHASE_1)
      mix_fn = (b & c) | (~b & d);
    else if (i < shm_pkg::PHASE_2)
      mix_fn = b ^ c ^ d;
    else if (i < shm_pkg::PHASE_3)
      mix_fn = (b & c) | (b & d) | (c & d);
    else
      mix_fn = b ^ c ^ d;
  endfunction

  function automatic logic [31:0] k_fn(input logic [6:0] i);
    if (i < shm_pkg::PHASE_1)
      k_fn = shm_pkg::K_0;
    else if (i < shm_pkg::PHASE_2)
      k_fn = shm_pkg::K_1;
    else if (i < shm_pkg::PHASE_3)
      k_fn = shm_pkg::K_2;
    else
      k_fn = shm_pkg::K_3;
  endfunction

  wire logic [31:0] mix_w = mix_fn(rif.idx, rif.b, rif.c, rif.d);
  wire logic [31:0] k_w   = k_fn(rif.idx);

  assign rif.a_n = rotl(rif.a, 5) + mix_w + rif.e + k_w + rif.w;
  assign rif.c_n = rotl(rif.b, 30);

endmodule // shm_round

// ---- rtl/shm_core.sv ----
// shm_core: memory-mapped sha-1 mac coprocessor, one 512-bit block
`timescale 1ns/1ps

module shm_core #(
  parameter bit ADD_IV = 1'b0  // add chaining value to final state
) (
  input  wire logic        clk_sys_i,         // 200 MHz clock
  input  wire logic        rst_i,             // sync reset, active high
  input  wire logic        select_n_i,        // access select, low
  input  wire logic        write_strobe_n_i,  // write strobe, low
  input  wire logic [4:0]  addr_i,            // word address
  input  wire logic [31:0] write_data_bus_i,  // write data
  input  wire logic        start_i,           // start pulse
  output logic      [31:0] read_data_bus_o,   // registered read data
  output logic             busy_o             // computation running
);

  // ****************************************
  // state
  // ****************************************
  shm_pkg::shm_state_e state_q;
  shm_pkg::shm_state_e state_d;
  logic [31:0] msg_buf_q [shm_pkg::BUF_WORDS];
  logic [31:0] a_q;
  logic [31:0] b_q;
  logic [31:0] c_q;
  logic [31:0] d_q;
  logic [31:0] e_q;
  logic [6:0]  round_q;
  logic        busy_q;
  logic [31:0] rdata_q;

  shm_round_if rif ();

  shm_round u_round (
    .rif (rif.rnd)
  );

  function automatic logic [31:0] rotl1(input logic [31:0] x);
    rotl1 = {x[30:0], x[31]};
  endfunction

  // ****************************************
  // decode
  // ****************************************
  wire logic        running   = (state_q == shm_pkg::SHM_RUN);
  wire logic        sel_w     = ~select_n_i;
  wire logic        wr_w      = sel_w & ~write_strobe_n_i;
  wire logic        rd_w      = sel_w & write_strobe_n_i;
  wire logic        buf_hit   = (addr_i <= shm_pkg::BUF_LAST);
  wire logic        buf_wr    = wr_w & buf_hit & ~running;
  wire logic        start_ok  = start_i & ~running;
  wire logic        last_rnd  = (round_q == shm_pkg::ROUND_LAST);
  wire logic        sched     = (round_q >= shm_pkg::SCHED_FROM);
  wire logic [3:0]  slot      = round_q[3:0];

  // circular schedule: slot holds w[t-16] before it is overwritten
  wire logic [31:0] w_calc = rotl1(msg_buf_q[4'(slot + 4'hD)]
                                 ^ msg_buf_q[4'(slot + 4'h8)]
                                 ^ msg_buf_q[4'(slot + 4'h2)]
                                 ^ msg_buf_q[slot]);
  wire logic [31:0] w_cur  = sched ? w_calc : msg_buf_q[slot];

  // ****************************************
  // result words
  // ****************************************
  // feed-forward is optional: the raw state is the default form
  function automatic logic [31:0] res_fn(input logic [31:0] v,
                                         input logic [31:0] iv);
    res_fn = ADD_IV ? 32'(v + iv) : v;
  endfunction

  wire logic [31:0] res_a = res_fn(a_q, shm_pkg::IV_A);
  wire logic [31:0] res_b = res_fn(b_q, shm_pkg::IV_B);
  wire logic [31:0] res_c = res_fn(c_q, shm_pkg::IV_C);
  wire logic [31:0] res_d = res_fn(d_q, shm_pkg::IV_D);
  wire logic [31:0] res_e = res_fn(e_q, shm_pkg::IV_E);

  // ****************************************
  // read selection
  // ****************************************
  // unmapped addresses return zero; reads while busy see working state
  wire logic [31:0] rd_mux =
    buf_hit                  ? msg_buf_q[addr_i[3:0]] :
    addr_i == shm_pkg::RES_A ? res_a :
    addr_i == shm_pkg::RES_B ? res_b :
    addr_i == shm_pkg::RES_C ? res_c :
    addr_i == shm_pkg::RES_D ? res_d :
    addr_i == shm_pkg::RES_E ? res_e :
    32'h0000_0000;

  assign rif.a   = a_q;
  assign rif.b   = b_q;
  assign rif.c   = c_q;
  assign rif.d   = d_q;
  assign rif.e   = e_q;
  assign rif.w   = w_cur;
  assign rif.idx = round_q;

  // ****************************************
  // control
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      shm_pkg::SHM_IDLE:
      begin
        if (start_ok)
          state_d = shm_pkg::SHM_RUN;
      end
      shm_pkg::SHM_RUN:
      begin
        if (last_rnd)
          state_d = shm_pkg::SHM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      state_q <= shm_pkg::SHM_IDLE;
    else
      state_q <= state_d;
  end

  // busy follows the next state so it rises with the start edge
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      busy_q <= 1'b0;
    else
      busy_q <= (state_d == shm_pkg::SHM_RUN);
  end

  // ****************************************
  // round counter
  // ****************************************
  wire logic [6:0]  round_d = running ? 7'(round_q + 7'h01) : 7'h00;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      round_q <= 7'h00;
    else
      round_q <= round_d;
  end

  // ****************************************
  // working variables
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      a_q <= 32'h0000_0000;
      b_q <= 32'h0000_0000;
      c_q <= 32'h0000_0000;
      d_q <= 32'h0000_0000;
      e_q <= 32'h0000_0000;
    end
    else if (start_ok)
    begin
      a_q <= shm_pkg::IV_A;
      b_q <= shm_pkg::IV_B;
      c_q <= shm_pkg::IV_C;
      d_q <= shm_pkg::IV_D;
      e_q <= shm_pkg::IV_E;
    end
    else if (running)
    begin
      a_q <= rif.a_n;
      b_q <= a_q;
      c_q <= rif.c_n;
      d_q <= c_q;
      e_q <= d_q;
    end
  end

  // ****************************************
  // message buffer
  // ****************************************
  for (genvar i = 0; i < shm_pkg::BUF_WORDS; i++)
  begin : g_buf
    wire logic host_wr  = buf_wr & (addr_i[3:0] == 4'(i));
    wire logic sched_wr = running & sched & (slot == 4'(i));
    always_ff @(posedge clk_sys_i)
    begin
      if (rst_i)
        msg_buf_q[i] <= 32'h0000_0000;
      else if (host_wr)
        msg_buf_q[i] <= write_data_bus_i;
      else if (sched_wr)
        msg_buf_q[i] <= w_calc;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      rdata_q <= 32'h0000_0000;
    else if (rd_w)
      rdata_q <= rd_mux;
  end

  assign read_data_bus_o = rdata_q;
  assign busy_o          = busy_q;

endmodule // shm_core

// ---- sim/shm_core_checker.sv ----
// shm_core_checker: port-level assertions for shm_core
`timescale 1ns/1ps
module shm_core_checker (
  input wire logic        clk_sys_i,        // clock
  input wire logic        rst_i,            // reset
  input wire logic        select_n_i,       // select, low
  input wire logic        write_strobe_n_i, // write strobe, low
  input wire logic [4:0]  addr_i,           // address
  input wire logic [31:0] write_data_bus_i, // write data
  input wire logic        start_i,          // start
  input wire logic [31:0] read_data_bus_o,  // read data
  input wire logic        busy_o            // busy
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  assign cnt_d = busy_o ? cnt_q + 8'h01 : 8'h00;
  always_ff @(posedge clk_sys_i)
    cnt_q <= rst_i ? 8'h00 : cnt_d;
  sequence s_take;
    start_i && !busy_o;
  endsequence
  sequence s_run;
    busy_o [*8];
  endsequence
  a_busy_run: assert property (s_take |=> s_run)
    else $error("busy did not rise after start");
  a_busy_quiet: assert property (!busy_o && !start_i |=> !busy_o)
    else $error("busy rose without start");
  a_busy_len: assert property ($fell(busy_o) |-> cnt_q == 8'h50)
    else $error("busy length wrong");
  a_busy_cap: assert property (busy_o |-> cnt_q < 8'h50)
    else $error("busy too long");
  a_rd_unmapped: assert property (!select_n_i && write_strobe_n_i
    && addr_i > 5'h14 |=> read_data_bus_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rd_stands: assert property (select_n_i |=> $stable(read_data_bus_o))
    else $error("read data changed without read");
  a_rst_clear: assert property ($fell(rst_i) |-> !busy_o
    && read_data_bus_o == 32'h0000_0000)
    else $error("reset did not clear outputs");
endmodule // shm_core_checker

bind shm_core shm_core_checker u_shm_core_checker (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .select_n_i(select_n_i),
  .write_strobe_n_i(write_strobe_n_i), .addr_i(addr_i),
  .write_data_bus_i(write_data_bus_i), .start_i(start_i),
  .read_data_bus_o(read_data_bus_o), .busy_o(busy_o));

// ---- sim/shm_host_model.sv ----
// shm_host_model: host processor side of the coprocessor bus
`timescale 1ns/1ps
module shm_host_model (
  input  wire logic        clk_sys_i, // clock
  input  wire logic [31:0] rdata_i,   // read data
  output logic             sel_n_o,   // select, low
  output logic             wr_n_o,    // write strobe, low
  output logic      [4:0]  addr_o,    // address
  output logic      [31:0] wdata_o,   // write data
  output logic             start_o    // start pulse
);
  initial
  begin
    sel_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 5'h00;
    wdata_o = 32'h0000_0000;
    start_o = 1'b0;
  end
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys_i);
    #1;
    sel_n_o = 1'b0;
    wr_n_o = w;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_sys_i);
    #1;
    q = rdata_i;
    sel_n_o = 1'b1;
    wr_n_o = 1'b1;
    // released lines show no stale value
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic run();
    @(posedge clk_sys_i);
    #1;
    start_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    start_o = 1'b0;
  endtask
  function automatic logic match(input logic [31:0] r [5],
                                 input logic [159:0] s);
    logic [159:0] b;
    b = 160'h0;
    for (int i = 4; i >= 0; i--)
      for (int j = 0; j < 4; j++)
        b = {b[151:0], r[i][8*j +: 8]};
    return b === s;
  endfunction
endmodule // shm_host_model

// ---- sim/shm_core_test.sv ----
// shm_core_test: self-checking bench for shm_core
`timescale 1ns/1ps
module shm_core_test;
  logic        clk_sys_i;
  logic        rst_i = 1'b1;
  logic        sel_n;
  logic        wr_n;
  logic        start;
  logic        busy;
  logic [4:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [31:0] x = 32'h0000_0058;
  logic [31:0] m [16];
  logic [31:0] r [5];
  logic [31:0] res [5];
  logic [31:0] kat [5] = '{32'h4254_1B35, 32'h5738_D5E1, 32'h2183_4873,
                           32'h681E_6DF6, 32'hD8FD_F6AD};
  int          fail_count = 0;
  int          tests_run = 0;
  int          n;
  shm_core u_shm_core (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .select_n_i(sel_n), .write_strobe_n_i(wr_n), .addr_i(addr),
    .write_data_bus_i(wdata), .start_i(start), .read_data_bus_o(rdata),
    .busy_o(busy));
  shm_host_model u_shm_host_model (.clk_sys_i(clk_sys_i), .rdata_i(rdata),
    .sel_n_o(sel_n), .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata),
    .start_o(start));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic model();
    logic [31:0] w [80];
    logic [31:0] a, b, c, d, e, f, k, t;
    a = shm_pkg::IV_A;
    b = shm_pkg::IV_B;
    c = shm_pkg::IV_C;
    d = shm_pkg::IV_D;
    e = shm_pkg::IV_E;
    for (int i = 0; i < 80; i++)
    begin
      t = i < 16 ? m[i] : w[i-3] ^ w[i-8] ^ w[i-14] ^ w[i-16];
      w[i] = i < 16 ? t : {t[30:0], t[31]};
      f = i < 20 ? (b & c) | (~b & d)
        : (i >= 40 && i < 60) ? (b & c) | (b & d) | (c & d) : b ^ c ^ d;
      k = i < 20 ? shm_pkg::K_0 : i < 40 ? shm_pkg::K_1
        : i < 60 ? shm_pkg::K_2 : shm_pkg::K_3;
      t = {a[26:0], a[31:27]} + f + e + k + w[i];
      e = d;
      d = c;
      c = {b[1:0], b[31:2]};
      b = a;
      a = t;
    end
    r = '{a, b, c, d, e};
  endtask
  task automatic blk(input logic kr);
    @(posedge clk_sys_i);
    #1;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    for (int i = 0; i < 32 && kr; i++)
    begin
      u_shm_host_model.acc(1'b1, i[4:0], 32'h0, q);
      chk(q, 32'h0);
    end
    for (int i = 0; i < 16; i++)
    begin
      m[i] = i == 0 ? 32'h6162_6380 : i == 15 ? 32'h0000_0018 : 32'h0;
      m[i] = kr ? m[i] : xs();
      u_shm_host_model.acc(1'b0, i[4:0], m[i], q);
    end
    for (int i = 0; i < 16; i++)
    begin
      u_shm_host_model.acc(1'b1, i[4:0], 32'h0, q);
      chk(q, m[i]);
    end
    u_shm_host_model.acc(1'b0, 5'h12, xs(), q);
    u_shm_host_model.acc(1'b1, 5'h12, 32'h0, q);
    chk(q, 32'h0);
    model();
    u_shm_host_model.run();
    chk(busy, 32'h1);
    n = 0;
    while (busy === 1'b1 && n < 200)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk(n, 32'h0000_0050);
    for (int i = 0; i < 6; i++)
    begin
      u_shm_host_model.acc(1'b1, 5'h10 + i[4:0], 32'h0, q);
      chk(q, i == 5 ? 32'h0 : kr ? kat[i] : r[i]);
      if (i < 5)
        res[i] = q;
    end
    if (kr)
    begin
      chk(u_shm_host_model.match(res,
        160'hADF6_FDD8_F66D_1E68_7348_8321_E1D5_3857_351B_5442), 32'h1);
      res[0][0] = ~res[0][0];
      chk(u_shm_host_model.match(res,
        160'hADF6_FDD8_F66D_1E68_7348_8321_E1D5_3857_351B_5442), 32'h0);
    end
  endtask
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    #50000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    blk(1'b1);
    repeat (2) blk(1'b0);
    // a reset in mid computation must abort it cleanly
    u_shm_host_model.run();
    repeat (10) @(posedge clk_sys_i);
    blk(1'b0);
    complete_run();
  end
endmodule // shm_core_test
